// File: include/ftp_consts.vh
`ifndef FTP_CONSTS_VH
`define FTP_CONSTS_VH
// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define FTP_OFF_PORT 8'h00
`define FTP_OFF_RATE 8'h04
`define FTP_OFF_FRAME 8'h08
`define FTP_OFF_USER 8'h0c
`define FTP_OFF_LINK 8'h10
`define FTP_OFF_STAT 8'h14
`define FTP_OFF_NEG 8'h18
// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define FTP_F_MODE 1:0
`define FTP_F_TSRC 5:4
`define FTP_B_FEC 8
`define FTP_F_RIDX 3:0
`define FTP_B_STD 8
`define FTP_F_CONT 1:0
`define FTP_F_PTYPE 5:4
`define FTP_B_INV 8
`define FTP_F_ORDER 20:16
`define FTP_B_START 0
`define FTP_B_SLAVE 1
`define FTP_B_PROTO 2
`define FTP_F_HDLC 6:4
`define FTP_B_ETH 8
`define FTP_F_PTR 21:16
`define FTP_B_TXEN 0
`define FTP_B_CLKP 1
`define FTP_F_ETSRC 5:4
`define FTP_B_LINKON 8
`define FTP_B_NEGD 16
// ---------------------------------------------------------------
// Encodings
// ---------------------------------------------------------------
`define FTP_MODE_OFF 2'h0
`define FTP_MODE_NORMAL 2'h1
`define FTP_MODE_THROUGH 2'h2
`define FTP_CONT_UNF 2'h0
`define FTP_CONT_CPRI 2'h1
`define FTP_CONT_OBSAI 2'h2
`define FTP_TSRC_INT 2'h0
`define FTP_TSRC_EXT 2'h1
`define FTP_TSRC_GPS 2'h2
`define FTP_TSRC_RCV 2'h3
`define FTP_PT_OFF 2'h0
`define FTP_PT_USER 2'h1
`define FTP_PT_PRBS 2'h2
`define FTP_STD_CPRI 1'b0
`define FTP_STD_OBSAI 1'b1
`define FTP_CPRI_MIN 4'h1
`define FTP_CPRI_MAX 4'ha
`define FTP_CPRI_FEC_A 4'h9
`define FTP_CPRI_FEC_B 4'ha
`define FTP_CPRI_V2_MIN 4'h5
`define FTP_OBSAI_MAX 4'h3
`define FTP_ORD_MIN 5'h0f
`define FTP_ORD_MAX 5'h1f
`define FTP_RESP_OK 2'h0
`define FTP_RESP_ERR 2'h2
// ---------------------------------------------------------------
// Reset values and generator constants
// ---------------------------------------------------------------
`define FTP_RST_RIDX 4'h1
`define FTP_RST_ORDER 5'h0f
`define FTP_RST_USER 32'h00000000
`define FTP_LFSR_SEED 31'h7fffffff
`define FTP_TAP15 31'h00006000
`define FTP_TAP16 31'h0000d008
`define FTP_TAP17 31'h00012000
`define FTP_TAP18 31'h00020400
`define FTP_TAP19 31'h00072000
`define FTP_TAP20 31'h00090000
`define FTP_TAP21 31'h00140000
`define FTP_TAP22 31'h00300000
`define FTP_TAP23 31'h00420000
`define FTP_TAP24 31'h00e10000
`define FTP_TAP25 31'h01200000
`define FTP_TAP26 31'h02000023
`define FTP_TAP27 31'h04000013
`define FTP_TAP28 31'h09000000
`define FTP_TAP29 31'h14000000
`define FTP_TAP30 31'h20000029
`define FTP_TAP31 31'h48000000
`endif

// File: hdl/ftp_port_config.v
// Summary of operation
// RL1 - Off mode disables the transmitter entirely
// RL2 - Normal mode sends our own generated pattern
// RL3 - Pass-through forces content to CPRI link
// RL4 - Pass-through locks timing to recovered clock
// RL5 - Four timing sources: internal, external, GPS, recovered
// RL6 - Clock-present flag for detected non-internal source
// RL7 - FEC allowed only at the two top rates; code checks the configured rate, not the negotiated one
// RL8 - FEC applies Reed-Solomon to 64B/66B blocks
// RL9 - Content unframed/CPRI/OBSAI, limited by line standard
// RL10 - PRBS orders fifteen through thirty-one supported
// RL11 - User 32-bit pattern only with framed content
// RL12 - Pattern off rejected with unframed content
// RL13 - Inversion acts only on PRBS patterns
// RL14 - Startup negotiates rate, protocol, management; report
// RL15 - Startup off applies configured link values directly
// RL16 - Slave role switches timing to recovered clock
// RL17 - Protocol v2 only at 4915.2 or higher; under startup the code passes negotiated v2 through without a rate check
// RL18 - Link settings act only in CPRI normal
// RL19 - Forced overrides are written back to storage
`timescale 1ns/1ps
`include "ftp_consts.vh"

module ftp_port_config #(
  parameter ADDR_W = 8
) (
  input wire aclk,
  input wire aresetn,
  input wire [ADDR_W-1:0] s_axi_awaddr,
  input wire [2:0] s_axi_awprot,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [ADDR_W-1:0] s_axi_araddr,
  input wire [2:0] s_axi_arprot,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire ext_clk_det,
  input wire gps_clk_det,
  input wire rx_clk_det,
  input wire rx_bit,
  input wire neg_done,
  input wire [3:0] neg_rate,
  input wire neg_proto_v2,
  input wire [2:0] neg_hdlc,
  output reg tx_enable,
  output reg tx_bit,
  output reg [1:0] tx_content,
  output reg [1:0] tx_clk_sel,
  output reg clk_present,
  output reg fec_active,
  output reg link_active,
  output reg link_startup,
  output reg link_slave,
  output reg [3:0] link_rate,
  output reg link_proto_v2,
  output reg [2:0] link_hdlc,
  output reg link_eth_en,
  output reg [5:0] link_eth_ptr
);

  // -------------------------------------------------------------
  // Configuration state
  // -------------------------------------------------------------
  reg [1:0] mode; // Port mode
  reg [1:0] tsrc; // Requested timing source
  reg fec_en; // FEC enable
  reg std; // Line standard, CPRI or OBSAI
  reg [3:0] ridx; // Line rate option
  reg [1:0] cont; // Frame content
  reg [1:0] ptype; // Pattern type
  reg inv; // PRBS inversion
  reg [4:0] order; // PRBS order
  reg [31:0] user_pat; // User pattern
  reg startup; // CPRI startup enable
  reg slave; // CPRI role
  reg proto_v2; // Protocol version 2
  reg [2:0] hdlc; // Slow management rate
  reg eth_en; // Fast management enable
  reg [5:0] eth_ptr; // Fast management pointer
  reg [1:0] next_mode;
  reg [1:0] next_tsrc;
  reg next_fec_en;
  reg next_std;
  reg [3:0] next_ridx;
  reg [1:0] next_cont;
  reg [1:0] next_ptype;
  reg next_inv;
  reg [4:0] next_order;
  reg [31:0] next_user_pat;
  reg next_startup;
  reg next_slave;
  reg next_proto_v2;
  reg [2:0] next_hdlc;
  reg next_eth_en;
  reg [5:0] next_eth_ptr;

  // -------------------------------------------------------------
  // AXI4-Lite write channel
  // -------------------------------------------------------------
  reg aw_held; // Write address captured
  reg w_held; // Write data captured
  reg [ADDR_W-1:0] wa; // Captured address
  reg [31:0] wd; // Captured data
  reg [3:0] ws; // Captured strobes
  wire do_write; // Both halves present, response free
  wire wr_hit; // Address maps to a writable register
  reg [31:0] wr_old; // Current word at the write address
  reg [31:0] wm; // Strobe-merged write word

  // Accept each half once, hold it until the write is done
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign do_write = aw_held && w_held && !s_axi_bvalid;
  assign wr_hit = (wa == `FTP_OFF_PORT) || (wa == `FTP_OFF_RATE) ||
                  (wa == `FTP_OFF_FRAME) || (wa == `FTP_OFF_USER) ||
                  (wa == `FTP_OFF_LINK);

  // Capture address, data and raise the response
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      wa <= {ADDR_W{1'b0}};
      wd <= 32'h00000000;
      ws <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `FTP_RESP_OK;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held <= 1'b1;
        wa <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held <= 1'b1;
        wd <= s_axi_wdata;
        ws <= s_axi_wstrb;
      end
      if (do_write)
      begin
        // Unmapped or read-only address answers SLVERR
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? `FTP_RESP_OK : `FTP_RESP_ERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // -------------------------------------------------------------
  // Register word images
  // -------------------------------------------------------------
  reg [31:0] img_port;
  reg [31:0] img_rate;
  reg [31:0] img_frame;
  reg [31:0] img_link;
  reg [31:0] img_stat;
  reg [31:0] img_neg;

  // Pack fields into words; unused bits read as zero
  always @*
  begin
    img_port = 32'h00000000;
    img_port[`FTP_F_MODE] = mode;
    img_port[`FTP_F_TSRC] = tsrc;
    img_port[`FTP_B_FEC] = fec_en;
    img_rate = 32'h00000000;
    img_rate[`FTP_F_RIDX] = ridx;
    img_rate[`FTP_B_STD] = std;
    img_frame = 32'h00000000;
    img_frame[`FTP_F_CONT] = cont;
    img_frame[`FTP_F_PTYPE] = ptype;
    img_frame[`FTP_B_INV] = inv;
    img_frame[`FTP_F_ORDER] = order;
    img_link = 32'h00000000;
    img_link[`FTP_B_START] = startup;
    img_link[`FTP_B_SLAVE] = slave;
    img_link[`FTP_B_PROTO] = proto_v2;
    img_link[`FTP_F_HDLC] = hdlc;
    img_link[`FTP_B_ETH] = eth_en;
    img_link[`FTP_F_PTR] = eth_ptr;
    img_stat = 32'h00000000;
    img_stat[`FTP_B_TXEN] = tx_enable;
    img_stat[`FTP_B_CLKP] = clk_present;
    img_stat[`FTP_F_ETSRC] = tx_clk_sel;
    img_stat[`FTP_B_LINKON] = link_active;
    img_stat[`FTP_B_NEGD] = neg_done;
    // Negotiated values, reported whatever startup says [RL14]
    img_neg = 32'h00000000;
    img_neg[`FTP_F_RIDX] = neg_rate;
    img_neg[`FTP_B_PROTO + 8] = neg_proto_v2;
    img_neg[`FTP_F_HDLC] = neg_hdlc;
    img_neg[`FTP_B_NEGD] = neg_done;
  end

  // Old word at the write address, then byte-lane merge
  always @*
  begin
    case (wa)
      `FTP_OFF_PORT: wr_old = img_port;
      `FTP_OFF_RATE: wr_old = img_rate;
      `FTP_OFF_FRAME: wr_old = img_frame;
      `FTP_OFF_USER: wr_old = user_pat;
      `FTP_OFF_LINK: wr_old = img_link;
      default: wr_old = 32'h00000000;
    endcase
    wm[7:0] = ws[0] ? wd[7:0] : wr_old[7:0];
    wm[15:8] = ws[1] ? wd[15:8] : wr_old[15:8];
    wm[23:16] = ws[2] ? wd[23:16] : wr_old[23:16];
    wm[31:24] = ws[3] ? wd[31:24] : wr_old[31:24];
  end

  // -------------------------------------------------------------
  // Write validation and cross-setting overrides
  // -------------------------------------------------------------
  wire rate_fec_ok; // Current rate allows FEC
  wire rate_v2_ok; // Current rate allows protocol 2
  assign rate_fec_ok = (next_std == `FTP_STD_CPRI) &&
                       ((next_ridx == `FTP_CPRI_FEC_A) || (next_ridx == `FTP_CPRI_FEC_B));
  assign rate_v2_ok = (next_std == `FTP_STD_CPRI) && (next_ridx >= `FTP_CPRI_V2_MIN);

  // Illegal field values leave the old value in place; a write is
  // checked against stored settings of other registers
  always @*
  begin
    next_mode = mode;
    next_tsrc = tsrc;
    next_fec_en = fec_en;
    next_std = std;
    next_ridx = ridx;
    next_cont = cont;
    next_ptype = ptype;
    next_inv = inv;
    next_order = order;
    next_user_pat = user_pat;
    next_startup = startup;
    next_slave = slave;
    next_proto_v2 = proto_v2;
    next_hdlc = hdlc;
    next_eth_en = eth_en;
    next_eth_ptr = eth_ptr;
    if (do_write)
    begin
      case (wa)
        `FTP_OFF_PORT:
        begin
          if (wm[`FTP_F_MODE] != 2'h3)
            next_mode = wm[`FTP_F_MODE];
          next_tsrc = wm[`FTP_F_TSRC]; // [RL5]
          next_fec_en = wm[`FTP_B_FEC];
        end
        `FTP_OFF_RATE:
        begin
          if (wm[`FTP_B_STD] == `FTP_STD_OBSAI ? wm[`FTP_F_RIDX] <= `FTP_OBSAI_MAX :
              (wm[`FTP_F_RIDX] >= `FTP_CPRI_MIN && wm[`FTP_F_RIDX] <= `FTP_CPRI_MAX))
          begin
            next_std = wm[`FTP_B_STD];
            next_ridx = wm[`FTP_F_RIDX];
          end
        end
        `FTP_OFF_FRAME:
        begin
          // Framed content must match the line standard [RL9]
          if (wm[`FTP_F_CONT] == `FTP_CONT_UNF ||
              (wm[`FTP_F_CONT] == `FTP_CONT_CPRI && std == `FTP_STD_CPRI) ||
              (wm[`FTP_F_CONT] == `FTP_CONT_OBSAI && std == `FTP_STD_OBSAI))
            next_cont = wm[`FTP_F_CONT];
          // User and off types need framed content [RL11] [RL12]
          if (wm[`FTP_F_PTYPE] == `FTP_PT_PRBS ||
              ((wm[`FTP_F_PTYPE] == `FTP_PT_USER || wm[`FTP_F_PTYPE] == `FTP_PT_OFF) &&
               next_cont != `FTP_CONT_UNF))
            next_ptype = wm[`FTP_F_PTYPE];
          next_inv = wm[`FTP_B_INV];
          if (wm[`FTP_F_ORDER] >= `FTP_ORD_MIN) // [RL10]
            next_order = wm[`FTP_F_ORDER];
        end
        `FTP_OFF_USER: next_user_pat = wm;
        `FTP_OFF_LINK:
        begin
          next_startup = wm[`FTP_B_START];
          next_slave = wm[`FTP_B_SLAVE];
          next_proto_v2 = wm[`FTP_B_PROTO];
          next_hdlc = wm[`FTP_F_HDLC];
          next_eth_en = wm[`FTP_B_ETH];
          next_eth_ptr = wm[`FTP_F_PTR];
        end
        default: next_mode = mode;
      endcase
    end
    // Overrides land in storage so readback shows the effect [RL19]
    if (next_cont == `FTP_CONT_CPRI && next_std != `FTP_STD_CPRI)
      next_cont = `FTP_CONT_UNF; // [RL9]
    if (next_cont == `FTP_CONT_OBSAI && next_std != `FTP_STD_OBSAI)
      next_cont = `FTP_CONT_UNF; // [RL9]
    if (next_mode == `FTP_MODE_THROUGH)
    begin
      next_cont = `FTP_CONT_CPRI; // [RL3]
      next_std = `FTP_STD_CPRI; // [RL3]
      if (next_ridx < `FTP_CPRI_MIN)
        next_ridx = `FTP_CPRI_MIN;
      next_tsrc = `FTP_TSRC_RCV; // [RL4]
    end
    if (next_cont == `FTP_CONT_UNF && next_ptype != `FTP_PT_PRBS)
      next_ptype = `FTP_PT_PRBS; // [RL11] [RL12]
    if (!rate_fec_ok)
      next_fec_en = 1'b0; // [RL7]
    if (!rate_v2_ok)
      next_proto_v2 = 1'b0; // [RL17]
    if (next_slave && next_mode == `FTP_MODE_NORMAL && next_cont == `FTP_CONT_CPRI)
      next_tsrc = `FTP_TSRC_RCV; // [RL16]
  end

  // Store configuration
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      mode <= `FTP_MODE_OFF;
      tsrc <= `FTP_TSRC_INT;
      fec_en <= 1'b0;
      std <= `FTP_STD_CPRI;
      ridx <= `FTP_RST_RIDX;
      cont <= `FTP_CONT_UNF;
      ptype <= `FTP_PT_PRBS;
      inv <= 1'b0;
      order <= `FTP_RST_ORDER;
      user_pat <= `FTP_RST_USER;
      startup <= 1'b0;
      slave <= 1'b0;
      proto_v2 <= 1'b0;
      hdlc <= 3'h0;
      eth_en <= 1'b0;
      eth_ptr <= 6'h00;
    end
    else
    begin
      mode <= next_mode;
      tsrc <= next_tsrc;
      fec_en <= next_fec_en;
      std <= next_std;
      ridx <= next_ridx;
      cont <= next_cont;
      ptype <= next_ptype;
      inv <= next_inv;
      order <= next_order;
      user_pat <= next_user_pat;
      startup <= next_startup;
      slave <= next_slave;
      proto_v2 <= next_proto_v2;
      hdlc <= next_hdlc;
      eth_en <= next_eth_en;
      eth_ptr <= next_eth_ptr;
    end
  end

  // -------------------------------------------------------------
  // AXI4-Lite read channel
  // -------------------------------------------------------------
  assign s_axi_arready = !s_axi_rvalid;

  // One-cycle read answer; unmapped reads give zero and SLVERR
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `FTP_RESP_OK;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `FTP_RESP_OK;
      case (s_axi_araddr)
        `FTP_OFF_PORT: s_axi_rdata <= img_port;
        `FTP_OFF_RATE: s_axi_rdata <= img_rate;
        `FTP_OFF_FRAME: s_axi_rdata <= img_frame;
        `FTP_OFF_USER: s_axi_rdata <= user_pat;
        `FTP_OFF_LINK: s_axi_rdata <= img_link;
        `FTP_OFF_STAT: s_axi_rdata <= img_stat;
        `FTP_OFF_NEG: s_axi_rdata <= img_neg;
        default:
        begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= `FTP_RESP_ERR;
        end
      endcase
    end
    else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // -------------------------------------------------------------
  // Pattern generator
  // -------------------------------------------------------------
  reg [30:0] lfsr; // Fibonacci shift register, newest bit low
  reg [30:0] taps; // Tap mask for the chosen order
  reg [4:0] upos; // User pattern bit position
  reg [4:0] last_order; // Detects an order change to reseed
  wire fb; // Feedback and PRBS output bit

  // Tap mask per order; a stale high part is overwritten by the all-ones reseed
  always @*
  begin
    case (order)
      5'h0f: taps = `FTP_TAP15;
      5'h10: taps = `FTP_TAP16;
      5'h11: taps = `FTP_TAP17;
      5'h12: taps = `FTP_TAP18;
      5'h13: taps = `FTP_TAP19;
      5'h14: taps = `FTP_TAP20;
      5'h15: taps = `FTP_TAP21;
      5'h16: taps = `FTP_TAP22;
      5'h17: taps = `FTP_TAP23;
      5'h18: taps = `FTP_TAP24;
      5'h19: taps = `FTP_TAP25;
      5'h1a: taps = `FTP_TAP26;
      5'h1b: taps = `FTP_TAP27;
      5'h1c: taps = `FTP_TAP28;
      5'h1d: taps = `FTP_TAP29;
      5'h1e: taps = `FTP_TAP30;
      default: taps = `FTP_TAP31;
    endcase
  end
  assign fb = ^(lfsr & taps); // [RL10]

  // Advance generator one bit per clock; reseed on order change so
  // the register never locks at all zeros
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      lfsr <= `FTP_LFSR_SEED;
      upos <= 5'h00;
      last_order <= `FTP_RST_ORDER;
    end
    else
    begin
      last_order <= order;
      upos <= upos + 5'h01;
      if (order != last_order)
        lfsr <= `FTP_LFSR_SEED;
      else
        lfsr <= {lfsr[29:0], fb};
    end
  end

  // -------------------------------------------------------------
  // Transmit and link outputs
  // -------------------------------------------------------------
  wire link_on; // CPRI link settings in force
  reg next_tx_bit;
  assign link_on = (mode == `FTP_MODE_NORMAL) && (cont == `FTP_CONT_CPRI); // [RL18]

  // Select the transmitted bit for the current mode
  always @*
  begin
    case (mode)
      `FTP_MODE_NORMAL:
      begin
        case (ptype)
          `FTP_PT_PRBS: next_tx_bit = fb ^ inv; // [RL2] [RL13]
          `FTP_PT_USER: next_tx_bit = user_pat[upos]; // [RL11]
          default: next_tx_bit = 1'b0; // [RL12]
        endcase
      end
      `FTP_MODE_THROUGH: next_tx_bit = rx_bit;
      default: next_tx_bit = 1'b0; // [RL1]
    endcase
  end

  // Registered outputs toward the line side
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tx_enable <= 1'b0;
      tx_bit <= 1'b0;
      tx_content <= `FTP_CONT_UNF;
      tx_clk_sel <= `FTP_TSRC_INT;
      clk_present <= 1'b0;
      fec_active <= 1'b0;
      link_active <= 1'b0;
      link_startup <= 1'b0;
      link_slave <= 1'b0;
      link_rate <= `FTP_RST_RIDX;
      link_proto_v2 <= 1'b0;
      link_hdlc <= 3'h0;
      link_eth_en <= 1'b0;
      link_eth_ptr <= 6'h00;
    end
    else
    begin
      tx_enable <= (mode != `FTP_MODE_OFF); // [RL1]
      tx_bit <= next_tx_bit;
      tx_content <= cont;
      tx_clk_sel <= tsrc; // [RL4] [RL5]
      case (tsrc)
        `FTP_TSRC_EXT: clk_present <= ext_clk_det; // [RL6]
        `FTP_TSRC_GPS: clk_present <= gps_clk_det; // [RL6]
        `FTP_TSRC_RCV: clk_present <= rx_clk_det; // [RL6]
        default: clk_present <= 1'b0;
      endcase
      // RS FEC over the 64B/66B stream is done by the line coder
      fec_active <= fec_en && (mode != `FTP_MODE_OFF); // [RL8]
      link_active <= link_on;
      link_startup <= link_on && startup; // [RL14]
      link_slave <= link_on && slave;
      // Negotiated values win once startup negotiation is done [RL14] [RL15]
      if (link_on && startup && neg_done)
      begin
        link_rate <= neg_rate;
        link_proto_v2 <= neg_proto_v2;
        link_hdlc <= neg_hdlc;
      end
      else
      begin
        link_rate <= ridx; // [RL15]
        link_proto_v2 <= link_on && proto_v2; // [RL17]
        link_hdlc <= link_on ? hdlc : 3'h0;
      end
      link_eth_en <= link_on && eth_en;
      link_eth_ptr <= link_on ? eth_ptr : 6'h00;
    end
  end

endmodule // ftp_port_config

// File: tb/ftp_port_config_props.sv
`timescale 1ns/1ps
`include "ftp_consts.vh"
module ftp_port_config_props (
  input wire aclk,
  input wire aresetn,
  input wire ext_clk_det,
  input wire neg_done,
  input wire [3:0] neg_rate,
  input wire tx_enable,
  input wire [1:0] tx_content,
  input wire [1:0] tx_clk_sel,
  input wire clk_present,
  input wire fec_active,
  input wire link_active,
  input wire link_startup,
  input wire link_slave,
  input wire [3:0] link_rate,
  input wire link_proto_v2
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  off_quiet_a: assert property (!tx_enable |-> !fec_active && !link_active)
    else $error("active with port off");
  link_gate_a: assert property (!link_active |-> !link_startup && !link_slave)
    else $error("link fields outside link");
  link_cont_a: assert property (link_active |-> tx_enable && tx_content == `FTP_CONT_CPRI)
    else $error("link without cpri");
  clk_int_a: assert property ((tx_clk_sel == `FTP_TSRC_INT)[*3] |-> !clk_present)
    else $error("clock flag on internal");
  clk_ext_a: assert property ((tx_clk_sel == `FTP_TSRC_EXT && ext_clk_det)[*3] |-> clk_present)
    else $error("external clock missed");
  slave_rcv_a: assert property (link_slave[*3] |-> tx_clk_sel == `FTP_TSRC_RCV)
    else $error("slave not on rx clock");
  thru_rcv_a: assert property ((tx_enable && !link_active && tx_content == `FTP_CONT_CPRI)[*3]
    |-> tx_clk_sel == `FTP_TSRC_RCV)
    else $error("through not on rx clock");
  fec_rate_a: assert property ((fec_active && !link_startup)[*3]
    |-> link_rate == `FTP_CPRI_FEC_A || link_rate == `FTP_CPRI_FEC_B)
    else $error("fec at wrong rate");
  v2_rate_a: assert property ((link_proto_v2 && !link_startup)[*3]
    |-> link_rate >= `FTP_CPRI_V2_MIN)
    else $error("v2 below its rate");
  neg_rate_a: assert property ((link_startup && neg_done && $stable(neg_rate))[*3]
    |-> link_rate == neg_rate)
    else $error("negotiated rate unused");
  // Main scenarios reached
  cover property (link_slave);
  cover property (fec_active);
  cover property (link_startup && neg_done);
endmodule // ftp_port_config_props

// File: tb/ftp_peer_model.sv
`timescale 1ns/1ps
// Far-end radio unit: loops our line back and negotiates after a delay
module ftp_peer_model #(
  parameter NEG_WAIT = 12,
  parameter [3:0] NEG_RATE = 4'h7
) (
  input wire aclk,
  input wire aresetn,
  input wire tx_enable,
  input wire tx_bit,
  input wire link_startup,
  output reg rx_clk_det = 1'b0,
  output reg rx_bit = 1'b0,
  output reg neg_done = 1'b0,
  output reg [3:0] neg_rate = 4'h0,
  output reg neg_proto_v2 = 1'b0,
  output reg [2:0] neg_hdlc = 3'h0
);
  reg [7:0] cnt = 8'h00; // Settling timer
  // Idle line toggles so nothing stale passes for data
  always @(posedge aclk)
  begin
    rx_clk_det <= tx_enable;
    rx_bit <= tx_enable ? tx_bit : ~rx_bit;
  end
  // Answer slowly; invalid values shown until settled
  always @(posedge aclk)
  begin
    if (!aresetn || !link_startup)
    begin
      cnt <= 8'h00;
      neg_done <= 1'b0;
      neg_rate <= ~NEG_RATE;
    end
    else if (cnt < NEG_WAIT)
      cnt <= cnt + 8'h01;
    else
    begin
      neg_done <= 1'b1;
      neg_rate <= NEG_RATE;
      neg_proto_v2 <= 1'b1;
      neg_hdlc <= 3'h2;
    end
  end
endmodule // ftp_peer_model

// File: tb/ftp_port_config_tb.sv
`timescale 1ns/1ps
`include "ftp_consts.vh"
module ftp_port_config_tb;
  reg aclk = 1'b0, aresetn = 1'b0, ext_clk_det = 1'b0, gps_clk_det = 1'b0;
  reg [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  reg [31:0] s_axi_wdata = 32'h00000000, rv;
  reg s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  reg s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  reg [1:0] rsp;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire rx_clk_det, rx_bit, neg_done, neg_proto_v2, tx_enable, tx_bit, clk_present;
  wire fec_active, link_active, link_startup, link_slave, link_proto_v2;
  wire [1:0] s_axi_bresp, s_axi_rresp, tx_content, tx_clk_sel;
  wire [31:0] s_axi_rdata;
  wire [3:0] neg_rate, link_rate;
  wire [2:0] neg_hdlc;
  integer n_mismatch = 0, samples_checked = 0;
  always #2.5 aclk = ~aclk;
  ftp_port_config i_ftp_port_config (.*, .s_axi_awprot(3'h0), .s_axi_wstrb(4'hf),
    .s_axi_arprot(3'h0), .link_hdlc(), .link_eth_en(), .link_eth_ptr());
  ftp_peer_model i_ftp_peer_model (.*);
  // Four-state compare
  task ck(input [31:0] got, input [31:0] exp);
  begin
    samples_checked = samples_checked + 1;
    if (got !== exp)
    begin
      n_mismatch = n_mismatch + 1;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  end
  endtask
  // Write; each half dropped once taken
  task wr(input [7:0] a, input [31:0] d);
  integer n;
  reg ta, tw, tb;
  begin
    n = 0;
    tb = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!tb && n < 50)
    begin
      @(negedge aclk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tb = s_axi_bvalid;
      rsp = s_axi_bresp;
      n = n + 1;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    if (!tb) n_mismatch = n_mismatch + 1;
    repeat (4) @(negedge aclk);
  end
  endtask
  // Read, compare data
  task rd(input [7:0] a, input [31:0] e);
  integer n;
  reg ta, tr;
  begin
    n = 0;
    tr = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!tr && n < 50)
    begin
      @(negedge aclk);
      ta = s_axi_arvalid && s_axi_arready;
      tr = s_axi_rvalid;
      rv = s_axi_rdata;
      rsp = s_axi_rresp;
      n = n + 1;
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    if (!tr) n_mismatch = n_mismatch + 1;
    ck(rv, e);
    @(negedge aclk);
  end
  endtask
  task t_reset;
  begin
    rd(`FTP_OFF_FRAME, 32'h000f0020);
    ck(tx_enable, 1'b0);
    rd(8'h1c, 32'h00000000);
    ck(rsp, `FTP_RESP_ERR);
    wr(`FTP_OFF_STAT, 32'h00000001);
    ck(rsp, `FTP_RESP_ERR);
    $display("reset test done");
  end
  endtask
  task t_through;
  begin
    wr(`FTP_OFF_PORT, 32'h00000002);
    rd(`FTP_OFF_FRAME, 32'h000f0021);
    ck(tx_content, `FTP_CONT_CPRI);
    rd(`FTP_OFF_PORT, 32'h00000032);
    wr(`FTP_OFF_PORT, 32'h00000012);
    ck(tx_clk_sel, `FTP_TSRC_RCV);
    ck(link_active, 1'b0);
    $display("through test done");
  end
  endtask
  task t_tsrc;
  integer k;
  begin
    @(posedge aclk);
    ext_clk_det <= 1'b1;
    for (k = 0; k < 4; k = k + 1)
    begin
      wr(`FTP_OFF_PORT, 32'h00000001 | (k << 4));
      ck(tx_clk_sel, k);
      ck(clk_present, k == 1 || k == 3);
      ck(tx_enable, 1'b1);
    end
    wr(`FTP_OFF_PORT, 32'h00000000);
    ck(tx_enable, 1'b0);
    $display("timing test done");
  end
  endtask
  task t_fec;
  begin
    wr(`FTP_OFF_RATE, 32'h00000009);
    wr(`FTP_OFF_PORT, 32'h00000101);
    ck(fec_active, 1'b1);
    wr(`FTP_OFF_RATE, 32'h00000005);
    ck(fec_active, 1'b0);
    wr(`FTP_OFF_PORT, 32'h00000101);
    rd(`FTP_OFF_PORT, 32'h00000001);
    $display("fec test done");
  end
  endtask
  task t_frame;
  begin
    wr(`FTP_OFF_FRAME, 32'h000f0010);
    rd(`FTP_OFF_FRAME, 32'h000f0020);
    wr(`FTP_OFF_FRAME, 32'h000f0000);
    rd(`FTP_OFF_FRAME, 32'h000f0020);
    wr(`FTP_OFF_FRAME, 32'h001f0111);
    rd(`FTP_OFF_FRAME, 32'h001f0111);
    wr(`FTP_OFF_FRAME, 32'h000e0022);
    rd(`FTP_OFF_FRAME, 32'h001f0021);
    $display("frame test done");
  end
  endtask
  task t_link;
  integer n;
  begin
    wr(`FTP_OFF_LINK, 32'h00000006);
    ck({link_slave, link_proto_v2, tx_clk_sel}, 32'hf);
    wr(`FTP_OFF_RATE, 32'h00000001);
    ck({link_proto_v2, link_rate}, 32'h01);
    wr(`FTP_OFF_LINK, 32'h00000001);
    ck(tx_clk_sel, `FTP_TSRC_RCV);
    n = 0;
    while (!neg_done && n < 100)
    begin
      @(negedge aclk);
      n = n + 1;
    end
    repeat (4) @(negedge aclk);
    ck(link_rate, 32'h7);
    rd(`FTP_OFF_NEG, 32'h00010427);
    wr(`FTP_OFF_PORT, 32'h00000000);
    ck(link_startup, 1'b0);
    $display("link test done");
  end
  endtask
  task print_verdict;
  begin
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  end
  endtask
  // Watchdog, well past the run
  initial
  begin
    #100000;
    n_mismatch = n_mismatch + 1;
    print_verdict;
  end
  initial
  begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset;
    t_through;
    t_tsrc;
    t_fec;
    t_frame;
    t_link;
    print_verdict;
  end
endmodule // ftp_port_config_tb
bind ftp_port_config ftp_port_config_props i_ftp_port_config_props (.*);
